// ---- core/dbgw_defs.svh ----
// offsets, field positions, reset values and other constants of the debug register window
`ifndef DBGW_DEFS_SVH
`define DBGW_DEFS_SVH
`define DBGW_OFS_DIDR    12'h000
`define DBGW_OFS_WFAR    12'h018
`define DBGW_OFS_VCR     12'h01C
`define DBGW_OFS_ECR     12'h024
`define DBGW_OFS_DSCCR   12'h028
`define DBGW_OFS_H2T     12'h080
`define DBGW_OFS_ITR     12'h084
`define DBGW_OFS_DSCR    12'h088
`define DBGW_OFS_T2H     12'h08C
`define DBGW_OFS_DRCR    12'h090
`define DBGW_OFS_PCSR    12'h0A0
`define DBGW_OFS_CIDSR   12'h0A4
`define DBGW_OFS_BVR     12'h100
`define DBGW_OFS_BCR     12'h140
`define DBGW_OFS_WVR     12'h180
`define DBGW_OFS_WCR     12'h1C0
`define DBGW_OFS_OSLAR   12'h300
`define DBGW_OFS_OSLSR   12'h304
`define DBGW_OFS_OSSRR   12'h308
`define DBGW_OFS_PRCR    12'h310
`define DBGW_OFS_PRSR    12'h314
`define DBGW_OFS_ID_LO   12'hD00
`define DBGW_OFS_ID_HI   12'hDFC
`define DBGW_OFS_MGMT    12'hF00
`define DBGW_OFS_LAR     12'hFB0
`define DBGW_OFS_LSR     12'hFB4
`define DBGW_SLOT_SPAN   12'h020
`define DBGW_WFAR_STD    32'h0000_0008
`define DBGW_WFAR_CMPCT  32'h0000_0004
`define DBGW_DIDR_ARCH   4'h4
`define DBGW_OSLSR_VAL   32'h0000_0000
`define DBGW_LOCK_RESET  1'b1
`define DBGW_DSCR_RXF    30
`define DBGW_DSCR_TXF    29
`define DBGW_DRCR_HALT   0
`define DBGW_DRCR_RESTART 1
`define DBGW_PRCR_NOPD   0
`define DBGW_PRSR_PU     0
`define DBGW_PRSR_SPD    1
`endif

// ---- core/dbgw_pkg.sv ----
// types of the debug register window
package dbgw_pkg;
	typedef struct packed {
		logic [7:0][31:0] bvr;
		logic [7:0][31:0] bcr;
		logic [7:0][31:0] wvr;
		logic [7:0][31:0] wcr;
	} dbgw_cmp_t;

	typedef struct packed {
		logic [1:0]  core_rst_sync;
		logic [1:0]  apb_rst_sync;
		logic [1:0]  pwrdn_sync;
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
		logic        locked;
		logic [31:0] prcr;
		logic        sticky_pd;
		logic        halt_req;
		logic        restart_req;
		logic [31:0] wfar;
		logic [31:0] vcr;
		logic [31:0] dsccr;
		logic [31:0] h2t;
		logic [31:0] t2h;
		logic [31:0] dscr;
		logic        rx_full;
		logic        tx_full;
		logic [31:0] itr;
		logic        itr_valid;
		logic        vc_hit;
		dbgw_cmp_t   cmp;
	} dbgw_state_t;
endpackage

// ---- core/dbgw_regmap.sv ----
// memory-mapped debug register window behind an apb3 slave port
`timescale 1ns/1ps
`default_nettype none
`include "dbgw_defs.svh"

// Behaviour
// (RULE1) Registers are reached through an APB3 slave with ready and error answers.
// (RULE2) Map sits on a 4KB boundary; only address bits 11:0 are decoded.
// (RULE3) Event catch slot at 0x024 reads zero although listed read-write.
// (RULE4) Sample slots 0x0A0, 0x0A4 and all reserved ranges read zero.
// (RULE5) Instruction transfer 0x084 and run control 0x090 are write-only.
// (RULE6) Eight breakpoint value/control slots; unconfigured ones read zero.
// (RULE7) Eight watchpoint value/control slots; unconfigured ones read zero.
// (RULE8) Read-only processor identification at 0xD00 to 0xDFC.
// (RULE9) Vector catch arms breakpoints on the exception vector addresses.
// (RULE10) Fault address captures address plus eight, or plus four in compact state.
// (RULE11) Identification, run control, power control/status and management live in debug domain.
// (RULE12) All other implemented registers belong to the core domain.
// (RULE13) Core-domain access while core is dormant or shut down answers error.
// (RULE14) System power-on reset clears both debug and core domain state.
// (RULE15) Core debug reset clears only core-domain state.
// (RULE16) APB debug reset clears debug-domain state; it, not core debug reset, restores the lock.
// (RULE17) System filters unprivileged accesses; no privilege signal arrives here.
// (RULE18) Locked writes are ignored unless flagged as from the external debugger; the code also lets writes to lock access 0xFB0 through.
// (RULE19) System raises the debugger-origin flag on every external debugger access.
// (RULE20) No OS lock: access and save slots read zero, status is read-only.
// (RULE21) Writes to read-zero slots finish without error and change nothing.
module dbgw_regmap
	import dbgw_pkg::*;
#(
	parameter int unsigned NUM_BRP    = 8,
	parameter int unsigned NUM_WRP    = 8,
	parameter logic [3:0]  VARIANT    = 4'h0,  // arbitrary value
	parameter logic [3:0]  REVISION   = 4'h0,  // arbitrary value
	parameter logic [31:0] PROC_ID    = 32'h0000_0000,  // arbitrary value
	parameter logic [31:0] UNLOCK_KEY = 32'h0000_0001
)(
	// clock and resets
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        core_debug_reset_n,
	input  wire logic        apb_debug_reset_n,
	// apb3 slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        debugger_origin_flag,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// core power state, asynchronous
	input  wire logic        core_powered_down,
	// core side events
	input  wire logic        wp_hit,
	input  wire logic [31:0] wp_addr,
	input  wire logic        wp_compact,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_addr,
	input  wire logic [31:5] vector_base,
	input  wire logic        core_rx_read,
	input  wire logic        core_tx_write,
	input  wire logic [31:0] core_tx_data,
	// core side controls
	output logic             halt_request,
	output logic             restart_request,
	output logic             instr_valid,
	output logic [31:0]      instr_word,
	output logic [31:0]      host_data,
	output logic             vector_catch_hit,
	output logic             core_no_powerdown,
	output dbgw_cmp_t        cmp_cfg
);

	dbgw_state_t st_q;
	dbgw_state_t st_d;

	// word-aligned offset; upper system bits never reach this block
	function automatic logic [11:0] word_ofs(input logic [11:0] a);
		return {a[11:2], 2'b00};  // RULE2
	endfunction

	// slot number and whether it falls in a configured pair
	function automatic logic slot_in(input logic [11:0] a, input logic [11:0] base,
			input int unsigned count);
		logic [11:0] w;
		logic [2:0]  idx;
		w = word_ofs(a);
		idx = w[4:2];
		return (w >= base) && (w < base + `DBGW_SLOT_SPAN) && (int'(idx) < count);
	endfunction

	// debug domain covers identification, run control, power control/status, management
	function automatic logic is_core_reg(input logic [11:0] a);
		logic [11:0] w;
		w = word_ofs(a);
		if (w == `DBGW_OFS_DIDR || w == `DBGW_OFS_DRCR || w == `DBGW_OFS_PRCR ||
				w == `DBGW_OFS_PRSR || w >= `DBGW_OFS_MGMT) begin
			return 1'b0;  // RULE11
		end else if (w == `DBGW_OFS_WFAR || w == `DBGW_OFS_VCR || w == `DBGW_OFS_DSCCR ||
				w == `DBGW_OFS_H2T || w == `DBGW_OFS_ITR || w == `DBGW_OFS_DSCR ||
				w == `DBGW_OFS_T2H || w == `DBGW_OFS_OSLSR) begin
			return 1'b1;  // RULE12
		end else if (slot_in(a, `DBGW_OFS_BVR, NUM_BRP) || slot_in(a, `DBGW_OFS_BCR, NUM_BRP) ||
				slot_in(a, `DBGW_OFS_WVR, NUM_WRP) || slot_in(a, `DBGW_OFS_WCR, NUM_WRP)) begin
			return 1'b1;  // RULE12
		end else if (w >= `DBGW_OFS_ID_LO && w <= `DBGW_OFS_ID_HI) begin
			return 1'b1;  // RULE12
		end else begin
			return 1'b0;
		end
	endfunction

	function automatic logic [31:0] didr_value();
		return {4'(NUM_WRP - 1), 4'(NUM_BRP - 1), 4'h0, `DBGW_DIDR_ARCH, 8'h00,
			VARIANT, REVISION};
	endfunction

	logic [11:0] acc_w;
	logic [2:0]  acc_idx;
	logic        wr_allowed;
	logic [2:0]  vec_idx;

	always_comb begin
		st_d = st_q;
		acc_w = word_ofs(paddr);
		acc_idx = acc_w[4:2];
		vec_idx = fetch_addr[4:2];
		// lock access itself is always writable, else the lock could never open
		wr_allowed = !st_q.locked || debugger_origin_flag || acc_w == `DBGW_OFS_LAR;  // RULE18

		// first stage feeds only the second stage
		st_d.core_rst_sync = {st_q.core_rst_sync[0], ~core_debug_reset_n};
		st_d.apb_rst_sync  = {st_q.apb_rst_sync[0], ~apb_debug_reset_n};
		st_d.pwrdn_sync    = {st_q.pwrdn_sync[0], core_powered_down};

		st_d.halt_req    = 1'b0;
		st_d.restart_req = 1'b0;
		st_d.itr_valid   = 1'b0;
		st_d.ready       = 1'b0;

		st_d.vc_hit = fetch_valid && fetch_addr[31:5] == vector_base &&
			fetch_addr[1:0] == 2'b00 && st_q.vcr[vec_idx];  // RULE9

		if (core_rx_read) begin
			st_d.rx_full = 1'b0;
		end

		// one wait state: answer registered in the cycle after the access phase opens
		if (psel && penable && !st_q.ready) begin  // RULE1
			st_d.ready  = 1'b1;
			st_d.rdata  = 32'h0000_0000;
			st_d.slverr = 1'b0;
			if (st_q.pwrdn_sync[1] && is_core_reg(paddr)) begin
				st_d.slverr = 1'b1;  // RULE13
			end else if (pwrite) begin
				if (wr_allowed) begin
					if (acc_w == `DBGW_OFS_WFAR) begin
						st_d.wfar = pwdata;
					end else if (acc_w == `DBGW_OFS_VCR) begin
						st_d.vcr = pwdata;
					end else if (acc_w == `DBGW_OFS_DSCCR) begin
						st_d.dsccr = pwdata;
					end else if (acc_w == `DBGW_OFS_H2T) begin
						st_d.h2t = pwdata;
						st_d.rx_full = 1'b1;
					end else if (acc_w == `DBGW_OFS_ITR) begin
						st_d.itr = pwdata;  // RULE5
						st_d.itr_valid = 1'b1;
					end else if (acc_w == `DBGW_OFS_DSCR) begin
						st_d.dscr = pwdata;
					end else if (acc_w == `DBGW_OFS_T2H) begin
						st_d.t2h = pwdata;
					end else if (acc_w == `DBGW_OFS_DRCR) begin
						st_d.halt_req = pwdata[`DBGW_DRCR_HALT];  // RULE5
						st_d.restart_req = pwdata[`DBGW_DRCR_RESTART];
					end else if (slot_in(paddr, `DBGW_OFS_BVR, NUM_BRP)) begin
						st_d.cmp.bvr[acc_idx] = pwdata;  // RULE6
					end else if (slot_in(paddr, `DBGW_OFS_BCR, NUM_BRP)) begin
						st_d.cmp.bcr[acc_idx] = pwdata;  // RULE6
					end else if (slot_in(paddr, `DBGW_OFS_WVR, NUM_WRP)) begin
						st_d.cmp.wvr[acc_idx] = pwdata;  // RULE7
					end else if (slot_in(paddr, `DBGW_OFS_WCR, NUM_WRP)) begin
						st_d.cmp.wcr[acc_idx] = pwdata;  // RULE7
					end else if (acc_w == `DBGW_OFS_PRCR) begin
						st_d.prcr = pwdata;
					end else if (acc_w == `DBGW_OFS_LAR) begin
						st_d.locked = pwdata != UNLOCK_KEY;
					end
					// every other slot, os lock included, takes the write and keeps nothing
				end  // RULE21
			end else begin
				if (acc_w == `DBGW_OFS_DIDR) begin
					st_d.rdata = didr_value();
				end else if (acc_w == `DBGW_OFS_WFAR) begin
					st_d.rdata = st_q.wfar;
				end else if (acc_w == `DBGW_OFS_VCR) begin
					st_d.rdata = st_q.vcr;
				end else if (acc_w == `DBGW_OFS_ECR) begin
					st_d.rdata = 32'h0000_0000;  // RULE3
				end else if (acc_w == `DBGW_OFS_DSCCR) begin
					st_d.rdata = st_q.dsccr;
				end else if (acc_w == `DBGW_OFS_H2T) begin
					st_d.rdata = st_q.h2t;
				end else if (acc_w == `DBGW_OFS_DSCR) begin
					st_d.rdata = st_q.dscr;
					st_d.rdata[`DBGW_DSCR_RXF] = st_q.rx_full;
					st_d.rdata[`DBGW_DSCR_TXF] = st_q.tx_full;
				end else if (acc_w == `DBGW_OFS_T2H) begin
					st_d.rdata = st_q.t2h;
					st_d.tx_full = 1'b0;
				end else if (slot_in(paddr, `DBGW_OFS_BVR, NUM_BRP)) begin
					st_d.rdata = st_q.cmp.bvr[acc_idx];  // RULE6
				end else if (slot_in(paddr, `DBGW_OFS_BCR, NUM_BRP)) begin
					st_d.rdata = st_q.cmp.bcr[acc_idx];  // RULE6
				end else if (slot_in(paddr, `DBGW_OFS_WVR, NUM_WRP)) begin
					st_d.rdata = st_q.cmp.wvr[acc_idx];  // RULE7
				end else if (slot_in(paddr, `DBGW_OFS_WCR, NUM_WRP)) begin
					st_d.rdata = st_q.cmp.wcr[acc_idx];  // RULE7
				end else if (acc_w == `DBGW_OFS_OSLSR) begin
					st_d.rdata = `DBGW_OSLSR_VAL;  // RULE20
				end else if (acc_w == `DBGW_OFS_PRCR) begin
					st_d.rdata = st_q.prcr;
				end else if (acc_w == `DBGW_OFS_PRSR) begin
					st_d.rdata[`DBGW_PRSR_PU] = !st_q.pwrdn_sync[1];
					st_d.rdata[`DBGW_PRSR_SPD] = st_q.sticky_pd;
					st_d.sticky_pd = 1'b0;
				end else if (acc_w == `DBGW_OFS_ID_LO) begin
					st_d.rdata = PROC_ID;  // RULE8
				end else if (acc_w == `DBGW_OFS_LSR) begin
					st_d.rdata = {30'h0000_0000, st_q.locked, 1'b1};
				end
				// pc and context samples, os lock slots, write-only and reserved read zero
			end  // RULE4
		end

		// hardware sets placed after the clears so a same-cycle event is kept
		if (st_q.pwrdn_sync[1]) begin
			st_d.sticky_pd = 1'b1;
		end
		if (core_tx_write) begin
			st_d.t2h = core_tx_data;
			st_d.tx_full = 1'b1;
		end
		// captured after the bus write so a same-cycle hit is not lost
		if (wp_hit) begin
			st_d.wfar = wp_addr + (wp_compact ? `DBGW_WFAR_CMPCT : `DBGW_WFAR_STD);  // RULE10
		end

		if (st_q.core_rst_sync[1]) begin  // RULE15
			st_d.wfar      = 32'h0000_0000;
			st_d.vcr       = 32'h0000_0000;
			st_d.dsccr     = 32'h0000_0000;
			st_d.h2t       = 32'h0000_0000;
			st_d.t2h       = 32'h0000_0000;
			st_d.dscr      = 32'h0000_0000;
			st_d.rx_full   = 1'b0;
			st_d.tx_full   = 1'b0;
			st_d.itr       = 32'h0000_0000;
			st_d.itr_valid = 1'b0;
			st_d.vc_hit    = 1'b0;
			st_d.cmp       = '0;
		end
		if (st_q.apb_rst_sync[1]) begin  // RULE16
			st_d.locked      = `DBGW_LOCK_RESET;
			st_d.prcr        = 32'h0000_0000;
			st_d.sticky_pd   = 1'b0;
			st_d.halt_req    = 1'b0;
			st_d.restart_req = 1'b0;
			st_d.ready       = 1'b0;
			st_d.slverr      = 1'b0;
			st_d.rdata       = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin  // RULE14
			st_q        <= '0;
			st_q.locked <= `DBGW_LOCK_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata            = st_q.rdata;
	assign pready            = st_q.ready;
	assign pslverr           = st_q.slverr;
	assign halt_request      = st_q.halt_req;
	assign restart_request   = st_q.restart_req;
	assign instr_valid       = st_q.itr_valid;
	assign instr_word        = st_q.itr;
	assign host_data         = st_q.h2t;
	assign vector_catch_hit  = st_q.vc_hit;
	assign core_no_powerdown = st_q.prcr[`DBGW_PRCR_NOPD];
	assign cmp_cfg           = st_q.cmp;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_one_wait;
		psel && penable && !pready && !st_q.apb_rst_sync[1] |=> pready ##1 !pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("apb answer not one cycle late"); // RULE1

	property p_ecr_raz;
		psel && penable && !pready && !pwrite && word_ofs(paddr) == `DBGW_OFS_ECR &&
			!st_q.apb_rst_sync[1] |=> prdata == 32'h0000_0000;
	endproperty
	a_ecr_raz: assert property (p_ecr_raz) else $error("event catch slot not zero"); // RULE3

	property p_sample_raz;
		psel && penable && !pready && !pwrite && !st_q.apb_rst_sync[1] &&
			(word_ofs(paddr) == `DBGW_OFS_PCSR || word_ofs(paddr) == `DBGW_OFS_CIDSR)
			|=> prdata == 32'h0000_0000 && !pslverr;
	endproperty
	a_sample_raz: assert property (p_sample_raz) else $error("sample slot not zero"); // RULE4

	property p_wo_raz;
		psel && penable && !pready && !pwrite && !st_q.apb_rst_sync[1] &&
			(word_ofs(paddr) == `DBGW_OFS_ITR || word_ofs(paddr) == `DBGW_OFS_DRCR)
			|=> prdata == 32'h0000_0000;
	endproperty
	a_wo_raz: assert property (p_wo_raz) else $error("write-only slot read back data"); // RULE5

	property p_bp_beyond;
		psel && penable && !pready && !pwrite && !st_q.apb_rst_sync[1] &&
			word_ofs(paddr) >= `DBGW_OFS_BVR && word_ofs(paddr) < `DBGW_OFS_BCR &&
			int'(paddr[4:2]) >= NUM_BRP |=> prdata == 32'h0000_0000;
	endproperty
	a_bp_beyond: assert property (p_bp_beyond) // RULE6
		else $error("unconfigured breakpoint read data");

	property p_wp_beyond;
		psel && penable && !pready && !pwrite && !st_q.apb_rst_sync[1] &&
			word_ofs(paddr) >= `DBGW_OFS_WVR && word_ofs(paddr) < `DBGW_OFS_WCR &&
			int'(paddr[4:2]) >= NUM_WRP |=> prdata == 32'h0000_0000;
	endproperty
	a_wp_beyond: assert property (p_wp_beyond) // RULE7
		else $error("unconfigured watchpoint read data");

	property p_wfar;
		wp_hit && !wp_compact && !st_q.core_rst_sync[1] |=>
			st_q.wfar == $past(wp_addr) + `DBGW_WFAR_STD;
	endproperty
	a_wfar: assert property (p_wfar) else $error("fault address offset wrong"); // RULE10

	property p_core_err;
		psel && penable && !pready && st_q.pwrdn_sync[1] && !st_q.apb_rst_sync[1] &&
			word_ofs(paddr) == `DBGW_OFS_VCR |=> pready && pslverr;
	endproperty
	a_core_err: assert property (p_core_err) // RULE13
		else $error("no error on core register while down");

	property p_dbg_ok;
		psel && penable && !pready && !st_q.apb_rst_sync[1] &&
			word_ofs(paddr) == `DBGW_OFS_DIDR |=> pready && !pslverr;
	endproperty
	a_dbg_ok: assert property (p_dbg_ok) else $error("debug domain register refused"); // RULE11

	property p_raz_wr;
		psel && penable && !pready && pwrite && !st_q.apb_rst_sync[1] &&
			word_ofs(paddr) == `DBGW_OFS_ECR |=> pready && !pslverr;
	endproperty
	a_raz_wr: assert property (p_raz_wr) else $error("zero slot write refused"); // RULE21

	property p_core_rst_keeps_debug;
		st_q.core_rst_sync[1] && !st_q.apb_rst_sync[1] && !(psel && penable)
			|=> st_q.prcr == $past(st_q.prcr);
	endproperty
	a_core_rst_keeps_debug: assert property (p_core_rst_keeps_debug) // RULE15
		else $error("core reset hit debug domain");

	property p_core_clr;
		st_q.core_rst_sync[1] |=> cmp_cfg == '0 && st_q.wfar == 32'h0000_0000;
	endproperty
	a_core_clr: assert property (p_core_clr) else $error("core reset left state"); // RULE15

	property p_apb_rst_lock;
		st_q.apb_rst_sync[1] |=> st_q.locked == `DBGW_LOCK_RESET;
	endproperty
	a_apb_rst_lock: assert property (p_apb_rst_lock) else $error("lock not restored"); // RULE16

	property p_lock_ignores;
		psel && penable && !pready && pwrite && st_q.locked && !debugger_origin_flag &&
			word_ofs(paddr) == `DBGW_OFS_VCR && !st_q.core_rst_sync[1] |=> $stable(st_q.vcr);
	endproperty
	a_lock_ignores: assert property (p_lock_ignores) // RULE18
		else $error("locked write took effect");

endmodule
`default_nettype wire

// ---- testbench/dbgw_apb_master.sv ----
// apb3 master standing in for the external debugger or system interconnect
`timescale 1ns/1ps
`default_nettype none
module dbgw_apb_master (
	// clock
	input  wire logic        clk,
	// apb3 request
	output var logic         psel,
	output var logic         penable,
	output var logic         pwrite,
	output var logic [11:0]  paddr,
	output var logic [31:0]  pwdata,
	output var logic         debugger_origin_flag,
	// apb3 answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		debugger_origin_flag = 1'b0;
	end

	// only privileged or debugger traffic is ever issued here
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic dbg, output logic [31:0] rd, output logic err, output logic ok);
		ok = 1'b0;
		rd = 32'h0000_0000;
		err = 1'b0;
		@(posedge clk);
		#1;
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		debugger_origin_flag = dbg;
		@(posedge clk);
		#1;
		penable = 1'b1;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			#1;
			if (pready === 1'b1) begin
				ok = 1'b1;
				rd = prdata;
				err = pslverr;
			end
		end
		@(posedge clk);
		#1;
		// released lines must not look like the last value
		psel = 1'b0;
		penable = 1'b0;
		paddr = ~paddr;
		pwdata = ~pwdata;
	endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the debug register window
`timescale 1ns/1ps
`default_nettype none
`include "dbgw_defs.svh"
module tb_top;
	localparam int NB = 6;
	localparam int NW = 4;
	localparam logic [31:0] PID = 32'hA5A5_0001;  // arbitrary value
	localparam logic [31:0] ID = {4'(NW - 1), 4'(NB - 1), 4'h0, `DBGW_DIDR_ARCH, 16'h0000};

	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} dbgw_row_t;

	logic clk = 1'b0, reset = 1'b1, core_debug_reset_n = 1'b1, apb_debug_reset_n = 1'b1;
	logic psel, penable, pwrite, debugger_origin_flag, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, instr_word, host_data;
	logic core_powered_down = 1'b0, wp_hit = 1'b0, wp_compact = 1'b0, fetch_valid = 1'b0;
	logic [31:0] wp_addr = 32'h0000_2000, fetch_addr = 32'h0000_0000;
	logic [31:5] vector_base = 27'h000_0010;
	logic core_rx_read = 1'b0, core_tx_write = 1'b0;
	logic [31:0] core_tx_data = 32'h0000_0000;
	logic halt_request, restart_request, instr_valid, vector_catch_hit, core_no_powerdown;
	dbgw_pkg::dbgw_cmp_t cmp_cfg;
	logic [31:0] n_halt = '0, n_rst = '0, n_instr = '0, n_vc = '0, h, r, v;
	int n_fail = 0;
	int total_checks = 0;

	dbgw_row_t rows [0:21] = '{
		'{12'h018, 32'h1234_5678, 32'h1234_5678}, '{12'h000, '1, ID},
		'{12'h024, '1, '0}, '{12'h004, '1, '0}, '{12'h0A0, '1, '0},
		'{12'h0A4, '1, '0}, '{12'h200, '1, '0}, '{12'hE00, '1, '0},
		'{12'h084, 32'hDEAD_BEEF, '0}, '{12'h090, '0, '0},
		'{12'h100, 32'h1000, 32'h1000}, '{12'h114, 32'h2000, 32'h2000},
		'{12'h118, 32'h3000, '0}, '{12'h180, 32'h4000, 32'h4000},
		'{12'h18C, 32'h5000, 32'h5000}, '{12'h190, 32'h6000, '0},
		'{12'h01C, 32'h4, 32'h4}, '{12'h300, '1, '0}, '{12'h308, '1, '0},
		'{12'h304, '1, `DBGW_OSLSR_VAL}, '{12'hD00, '0, PID}, '{12'hD04, '1, '0}
	};

	dbgw_regmap #(.NUM_BRP(NB), .NUM_WRP(NW), .PROC_ID(PID)) dut_u (
		.clk, .reset, .core_debug_reset_n, .apb_debug_reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .debugger_origin_flag, .prdata, .pready, .pslverr,
		.core_powered_down, .wp_hit, .wp_addr, .wp_compact, .fetch_valid, .fetch_addr,
		.vector_base, .core_rx_read, .core_tx_write, .core_tx_data, .halt_request,
		.restart_request, .instr_valid, .instr_word, .host_data, .vector_catch_hit,
		.core_no_powerdown, .cmp_cfg
	);

	dbgw_apb_master mst_u (
		.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .debugger_origin_flag,
		.prdata, .pready, .pslverr
	);

	always #5 clk = ~clk;

	// pulse outputs stand one cycle, so count them at every edge
	always @(posedge clk) begin
		n_halt <= n_halt + {31'h0, halt_request === 1'b1};
		n_rst <= n_rst + {31'h0, restart_request === 1'b1};
		n_instr <= n_instr + {31'h0, instr_valid === 1'b1};
		n_vc <= n_vc + {31'h0, vector_catch_hit === 1'b1};
	end

	task automatic stop_test;
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic dbg, input logic [31:0] e, input logic ee);
		logic [31:0] rv;
		logic        er;
		logic        ok;
		mst_u.xfer(w, a, d, dbg, rv, er, ok);
		if (!ok) begin
			n_fail++;
			stop_test();
		end
		chk({31'h0, er}, {31'h0, ee});
		if (!w && !ee) begin
			chk(rv, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// k 0: watch hit, 1: compact watch hit, 2: instruction fetch, 3: core channel read and write
	task automatic ev(input int k, input logic [31:0] a);
		cyc(1);
		wp_addr = a;
		fetch_addr = a;
		wp_compact = k[0];
		wp_hit = (k < 2);
		fetch_valid = (k == 2);
		core_tx_write = (k == 3);
		core_rx_read = (k == 3);
		core_tx_data = a;
		cyc(1);
		wp_hit = 1'b0;
		fetch_valid = 1'b0;
		core_tx_write = 1'b0;
		core_rx_read = 1'b0;
	endtask

	initial begin
		cyc(2);
		reset = 1'b0;
		chk({31'h0, |cmp_cfg}, '0);
		foreach (rows[i]) begin
			op(1'b1, rows[i].a, rows[i].d, 1'b1, '0, 1'b0);
			op(1'b0, rows[i].a, '0, 1'b1, rows[i].e, 1'b0);
		end
		op(1'b1, 12'h018, 32'h0BAD_0BAD, 1'b0, '0, 1'b0);
		op(1'b0, 12'h018, '0, 1'b0, 32'h1234_5678, 1'b0);
		op(1'b1, 12'h01C, 32'h0000_00FF, 1'b0, '0, 1'b0);
		op(1'b0, 12'h01C, '0, 1'b0, 32'h0000_0004, 1'b0);
		op(1'b1, 12'hFB0, 32'h1, 1'b0, '0, 1'b0);
		op(1'b1, 12'h018, 32'h0ACE, 1'b0, '0, 1'b0);
		op(1'b0, 12'h018, '0, 1'b0, 32'h0ACE, 1'b0);
		h = n_halt;
		r = n_rst;
		v = n_instr;
		op(1'b1, 12'h090, 32'h1, 1'b1, '0, 1'b0);
		op(1'b1, 12'h090, 32'h2, 1'b1, '0, 1'b0);
		op(1'b1, 12'h084, 32'hCAFE_F00D, 1'b1, '0, 1'b0);
		chk(n_halt, h + 32'h1);
		chk(n_rst, r + 32'h1);
		chk(n_instr, v + 32'h1);
		chk(instr_word, 32'hCAFE_F00D);
		op(1'b1, 12'h080, 32'h1357_9BDF, 1'b1, '0, 1'b0);
		chk(host_data, 32'h1357_9BDF);
		op(1'b0, 12'h088, '0, 1'b1, 32'h4000_0000, 1'b0);
		ev(3, 32'h2468_ACE0);
		op(1'b0, 12'h088, '0, 1'b1, 32'h2000_0000, 1'b0);
		op(1'b0, 12'h08C, '0, 1'b1, 32'h2468_ACE0, 1'b0);
		op(1'b0, 12'h088, '0, 1'b1, 32'h0000_0000, 1'b0);
		ev(0, 32'h0000_2000);
		op(1'b0, 12'h018, '0, 1'b1, 32'h0000_2008, 1'b0);
		ev(1, 32'h0000_3000);
		op(1'b0, 12'h018, '0, 1'b1, 32'h0000_3004, 1'b0);
		v = n_vc;
		ev(2, 32'h0000_0208);
		ev(2, 32'h0000_020C);
		cyc(2);
		chk(n_vc, v + 32'h1);
		core_powered_down = 1'b1;
		cyc(4);
		op(1'b0, 12'h018, '0, 1'b1, '0, 1'b1);
		op(1'b1, 12'h018, '1, 1'b1, '0, 1'b1);
		op(1'b0, 12'h000, '0, 1'b1, ID, 1'b0);
		op(1'b0, 12'h024, '0, 1'b1, '0, 1'b0);
		op(1'b0, 12'h314, '0, 1'b1, 32'h2, 1'b0);
		core_powered_down = 1'b0;
		cyc(4);
		op(1'b0, 12'h018, '0, 1'b1, 32'h0000_3004, 1'b0);
		op(1'b1, 12'h310, 32'h1, 1'b1, '0, 1'b0);
		chk({31'h0, core_no_powerdown}, 32'h1);
		core_debug_reset_n = 1'b0;
		cyc(4);
		core_debug_reset_n = 1'b1;
		cyc(4);
		op(1'b0, 12'h018, '0, 1'b1, '0, 1'b0);
		op(1'b0, 12'h100, '0, 1'b1, '0, 1'b0);
		op(1'b0, 12'hFB4, '0, 1'b1, 32'h1, 1'b0);
		chk({31'h0, core_no_powerdown}, 32'h1);
		op(1'b1, 12'h100, 32'h1000, 1'b1, '0, 1'b0);
		apb_debug_reset_n = 1'b0;
		cyc(4);
		apb_debug_reset_n = 1'b1;
		cyc(4);
		chk({31'h0, core_no_powerdown}, '0);
		op(1'b0, 12'hFB4, '0, 1'b1, 32'h3, 1'b0);
		op(1'b0, 12'h100, '0, 1'b1, 32'h1000, 1'b0);
		op(1'b1, 12'hFB0, 32'h1, 1'b1, '0, 1'b0);
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		op(1'b0, 12'h100, '0, 1'b1, '0, 1'b0);
		op(1'b0, 12'hFB4, '0, 1'b1, 32'h3, 1'b0);
		chk({31'h0, |cmp_cfg}, '0);
		stop_test();
	end
endmodule
`default_nettype wire
